/* dv/err_event_source.sv */
// link and transaction layer model issuing error event pulses
// assumes the bench calls send from a procedural thread
module err_event_source (
  input wire logic mclk_in,
  output logic bad_tlp_out,
  output logic bad_dllp_out,
  output logic [31:0] evt_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bad_tlp_out = 1'b0;
    bad_dllp_out = 1'b0;
    evt_out = 32'h0;
  end
  // one cycle only, so no packet is counted twice
  task automatic send(input logic t, input logic d, input logic [31:0] e);
    @(posedge mclk_in);
    bad_tlp_out <= t;
    bad_dllp_out <= d;
    evt_out <= e;
    @(posedge mclk_in);
    bad_tlp_out <= 1'b0;
    bad_dllp_out <= 1'b0;
    evt_out <= 32'h0;
  endtask
endmodule

/* dv/err_report_checker.sv */
// port assertions for the error accounting register set
// assumes binding into link_error_report_regs with its own parameters
module err_report_checker
  import err_report_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter bit HAS_INTERNAL_ERR = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // watched ports
  input wire logic cfg_rd_in,
  input wire logic cfg_rvalid_out,
  input wire logic [31:0] uncor_evt_in,
  input wire logic fatal_err_out,
  input wire logic nonfatal_err_out,
  input wire logic advisory_err_out,
  input wire logic [31:0] log_req_out
);
  localparam logic [31:0] LEGAL = COMMON_BITS | (IS_UPSTREAM ? 32'h0 : 32'h0020_0020)
    | (HAS_INTERNAL_ERR ? 32'h0040_0000 : 32'h0);
  wire logic any_ind = fatal_err_out | nonfatal_err_out | advisory_err_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  a_read_answered: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("read not answered");
  a_answer_cause: assert property (cfg_rvalid_out |-> $past(cfg_rd_in))
    else $error("read answer without read");
  a_log_cause: assert property (log_req_out != 0 |-> (log_req_out & ~$past(uncor_evt_in)) == 0)
    else $error("log request without event");
  a_reserved_quiet: assert property ((log_req_out & ~LEGAL) == 0)
    else $error("reserved position reported");
  a_report_given: assert property (log_req_out != 0 |-> any_ind)
    else $error("logged error gives no indication");
  a_report_cause: assert property (any_ind |-> log_req_out != 0)
    else $error("indication without logged error");
  a_advisory_kind: assert property (advisory_err_out |-> (log_req_out & ADVISORY_BITS) != 0)
    else $error("advisory from wrong error");
  a_nonfatal_kind: assert property (nonfatal_err_out |-> (log_req_out & ~ADVISORY_BITS) != 0)
    else $error("non-fatal from advisory error");
  a_reset_quiet: assert property ($rose(rstn_in) |-> !any_ind && log_req_out == 0)
    else $error("outputs busy after reset");
endmodule
bind link_error_report_regs err_report_checker #(
  .IS_UPSTREAM(IS_UPSTREAM),
  .HAS_INTERNAL_ERR(HAS_INTERNAL_ERR)
) u_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_rd_in(cfg_rd_in),
  .cfg_rvalid_out(cfg_rvalid_out), .uncor_evt_in(uncor_evt_in),
  .fatal_err_out(fatal_err_out), .nonfatal_err_out(nonfatal_err_out),
  .advisory_err_out(advisory_err_out), .log_req_out(log_req_out));

/* dv/link_error_report_regs_tb_top.sv */
// self-checking bench for the error accounting registers
// assumes the default upstream port without the internal error bit
module link_error_report_regs_tb_top;
  import err_report_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0;
  logic force_err_en_in = 1'b0;
  logic [11:0] cfg_addr_in = 12'h000;
  logic [31:0] cfg_wdata_in = 32'h0;
  logic bad_tlp_in, bad_dllp_in, cfg_rvalid_out, fatal_err_out, nonfatal_err_out;
  logic advisory_err_out;
  logic [31:0] uncor_evt_in, cfg_rdata_out, log_req_out, mask, sev, flags, evt, w;
  logic [34:0] e;
  // second port instance: downstream, with the internal error position present
  localparam logic [31:0] IMPL_DN = 32'h00FF_9030;
  logic [31:0] rdata_dn, log_dn, flags_dn;
  logic rvalid_dn, fatal_dn, nonfatal_dn, advisory_dn;
  int mismatches = 0;
  int checks_done = 0;
  int ntlp = 0;
  int ndllp = 0;
  always #5 mclk_in = ~mclk_in;
  link_error_report_regs dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(4'hF),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out), .force_err_en_in(force_err_en_in),
    .bad_tlp_in(bad_tlp_in), .bad_dllp_in(bad_dllp_in), .uncor_evt_in(uncor_evt_in),
    .fatal_err_out(fatal_err_out), .nonfatal_err_out(nonfatal_err_out),
    .advisory_err_out(advisory_err_out), .log_req_out(log_req_out));
  link_error_report_regs #(.IS_UPSTREAM(1'b0), .HAS_INTERNAL_ERR(1'b1)) dut_dn (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(4'hF),
    .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(rdata_dn),
    .cfg_rvalid_out(rvalid_dn), .force_err_en_in(force_err_en_in),
    .bad_tlp_in(bad_tlp_in), .bad_dllp_in(bad_dllp_in), .uncor_evt_in(uncor_evt_in),
    .fatal_err_out(fatal_dn), .nonfatal_err_out(nonfatal_dn),
    .advisory_err_out(advisory_dn), .log_req_out(log_dn));
  err_event_source src (.mclk_in(mclk_in), .bad_tlp_out(bad_tlp_in),
    .bad_dllp_out(bad_dllp_in), .evt_out(uncor_evt_in));
  function automatic logic [34:0] expect_ind(input logic [31:0] ev, m, s, impl);
    logic [31:0] l;
    l = ev & impl & ~m;
    return {|(l & s), |(l & ~s & ~ADVISORY_BITS), |(l & ~s & ADVISORY_BITS), l};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [31:0] exp_dn = 32'h0000_0000, input bit dn = 1'b0);
    @(posedge mclk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge mclk_in);
    cfg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, exp);
    if (dn) begin
      chk({31'h0, rvalid_dn}, 32'h1);
      chk(rdata_dn, exp_dn);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  initial begin
    void'($urandom(71));
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd(OFS_BAD_TLP_COUNT, 32'h0);
    rd(OFS_BAD_DLLP_COUNT, 32'h0);
    wr(OFS_CAP_HEADER, 32'h0);
    rd(OFS_CAP_HEADER, 32'h1381_0001, 32'h1481_0001, 1'b1);
    rd(OFS_UNCOR_MASKS, 32'h0040_0000, 32'h0040_0000, 1'b1);
    rd(OFS_UNCOR_FATALITY, 32'h0046_2030, 32'h0046_2030, 1'b1);
    wr(OFS_UNCOR_FATALITY, 32'h0000_0000);
    rd(OFS_UNCOR_FATALITY, 32'h0040_2020, 32'h0000_2000, 1'b1);
    rd(12'hFC4, 32'h0);
    wr(OFS_UNCOR_FATALITY, 32'hFFFF_FFFF);
    rd(OFS_UNCOR_FATALITY, 32'h00DF_B030, 32'h00FF_B030, 1'b1);
    wr(OFS_UNCOR_MASKS, 32'hFFFF_FFFF);
    rd(OFS_UNCOR_MASKS, 32'h00DF_9010, 32'h00FF_9030, 1'b1);
    flags = 32'h0;
    flags_dn = 32'h0;
    // one pass per status position first, then random mixes
    for (int i = 0; i < 64; i++) begin
      w = $urandom();
      mask = (i < 32) ? 32'h0040_0000 : (($urandom() & COMMON_BITS) | 32'h0040_0000);
      sev = ($urandom() & COMMON_BITS) | 32'h0040_2020;
      evt = (i < 32) ? (32'h1 << i) : $urandom();
      wr(OFS_UNCOR_MASKS, mask);
      wr(OFS_UNCOR_FATALITY, sev);
      src.send(w[0], w[1], evt);
      ntlp += int'(w[0]);
      ndllp += int'(w[1]);
      @(negedge mclk_in);
      e = expect_ind(evt, mask, sev, COMMON_BITS);
      chk(log_req_out, e[31:0]);
      chk({29'h0, fatal_err_out, nonfatal_err_out, advisory_err_out}, {29'h0, e[34:32]});
      e = expect_ind(evt, mask, sev, IMPL_DN);
      chk(log_dn, e[31:0]);
      chk({29'h0, fatal_dn, nonfatal_dn, advisory_dn}, {29'h0, e[34:32]});
      flags = flags | (evt & COMMON_BITS);
      flags_dn = flags_dn | (evt & IMPL_DN);
      rd(OFS_UNCOR_FLAGS, flags, flags_dn, 1'b1);
      rd(OFS_UNCOR_FATALITY, sev, sev, 1'b1);
      wr(OFS_UNCOR_FLAGS, w);
      flags = flags & ~w;
      flags_dn = flags_dn & ~w;
    end
    rd(OFS_UNCOR_FLAGS, flags, flags_dn, 1'b1);
    rd(OFS_BAD_TLP_COUNT, 32'(ntlp));
    rd(OFS_BAD_DLLP_COUNT, 32'(ndllp));
    wr(OFS_BAD_TLP_COUNT, 32'hFFFF_FFFE);
    wr(OFS_BAD_DLLP_COUNT, 32'hFFFF_FFFD);
    repeat (3) src.send(1'b1, 1'b0, 32'h0);
    rd(OFS_BAD_TLP_COUNT, 32'hFFFF_FFFF);
    rd(OFS_BAD_DLLP_COUNT, 32'hFFFF_FFFD);
    @(posedge mclk_in);
    force_err_en_in <= 1'b1;
    wr(OFS_UNCOR_FLAGS, 32'hFFFF_FFFF);
    rd(OFS_UNCOR_FLAGS, COMMON_BITS, IMPL_DN, 1'b1);
    wr(OFS_UNCOR_FLAGS, 32'h0000_1010);
    rd(OFS_UNCOR_FLAGS, 32'h0000_1010);
    @(posedge mclk_in);
    force_err_en_in <= 1'b0;
    wr(OFS_UNCOR_FLAGS, 32'h0000_0010);
    rd(OFS_UNCOR_FLAGS, 32'h0000_1000);
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd(OFS_UNCOR_FLAGS, 32'h0, 32'h0, 1'b1);
    end_of_test();
  end
endmodule

/* src/err_report_pkg.sv */
// constants for the per-port error accounting register set
// assumes a 12-bit configuration dword byte address and 32-bit data
package err_report_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_BAD_TLP_COUNT = 12'hFAC;
  localparam logic [11:0] OFS_BAD_DLLP_COUNT = 12'hFB0;
  localparam logic [11:0] OFS_CAP_HEADER = 12'hFB4;
  localparam logic [11:0] OFS_UNCOR_FLAGS = 12'hFB8;
  localparam logic [11:0] OFS_UNCOR_MASKS = 12'hFBC;
  localparam logic [11:0] OFS_UNCOR_FATALITY = 12'hFC0;

  // capability header fields
  localparam logic [15:0] CAP_ID = 16'h0001;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_CAP_UPSTREAM = 12'h138;
  localparam logic [11:0] NEXT_CAP_DOWNSTREAM = 12'h148;
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_VER_LSB = 16;
  localparam int NEXT_CAP_LSB = 20;

  // uncorrectable error bit positions
  localparam int BIT_DL_PROTOCOL = 4;
  localparam int BIT_SURPRISE_DOWN = 5;
  localparam int BIT_POISONED = 12;
  localparam int BIT_FC_PROTOCOL = 13;
  localparam int BIT_CPL_TIMEOUT = 14;
  localparam int BIT_CPL_ABORT = 15;
  localparam int BIT_UNEXP_CPL = 16;
  localparam int BIT_RX_OVERFLOW = 17;
  localparam int BIT_MALFORMED = 18;
  localparam int BIT_E2E_CRC = 19;
  localparam int BIT_UNSUP_REQ = 20;
  localparam int BIT_ACCESS_VIOL = 21;
  localparam int BIT_INTERNAL = 22;
  localparam int BIT_MC_BLOCKED = 23;

  // reset values
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASKS_RESET = 32'h0040_0000;
  localparam logic [31:0] FATALITY_RESET = 32'h0046_2030;

  // bits present on every port
  localparam logic [31:0] COMMON_BITS = 32'h009F_9010;
  // errors that turn advisory when their severity bit is zero
  localparam logic [31:0] ADVISORY_BITS = 32'h0039_9000;

endpackage

/* src/link_error_report_regs.sv */
// per-port error accounting registers: bad packet counters and the
// uncorrectable error status, mask and severity of the error capability
// assumes single-cycle config strobes; rstn_in is the fundamental reset
//
// Contract
// R1: count received TLPs with CRC or sequence errors
// R2: count received DLLPs the same, separately
// R3: counters saturate at all ones, never wrap
// R4: header reads ID 0001h and version 1h
// R5: next pointer 138h upstream, 148h downstream
// R6: bit 4 link protocol; bit 5 downstream only
// R7: bits 12, 15, 16 poisoned, abort, unexpected
// R8: bits 17, 18, 19 overflow, malformed, CRC
// R9: bits 20, 23 always; 21 downstream only
// R10: internal error bit 22 only where enabled
// R11: bits 13 and 14 reserved, never set; severity bit 13 still resets to one and always reads one
// R12: sticky write-one-clear; force mode makes read/write
// R13: mask bit suppresses reporting and logging
// R14: internal mask resets to one, others zero
// R15: severity one fatal; zero advisory where listed
// R16: listed severity bits reset to fatal
// R17: upstream surprise-down severity fixed fatal
// R18: unmasked error signals fatal or non-fatal; a listed error with severity zero signals advisory_err_out instead
module link_error_report_regs
  import err_report_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter bit HAS_INTERNAL_ERR = 1'b0,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // configuration access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // force-error enable held elsewhere in the port
  input wire logic force_err_en_in,
  // link and transaction layer events
  input wire logic bad_tlp_in,
  input wire logic bad_dllp_in,
  input wire logic [31:0] uncor_evt_in,
  // error indications
  output logic fatal_err_out,
  output logic nonfatal_err_out,
  output logic advisory_err_out,
  output logic [31:0] log_req_out
);

  generate
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie between 1 and 32");
    end
  endgenerate

  // bits that exist on this port
  function automatic logic [31:0] port_bits(input bit upstream, input bit internal);
    logic [31:0] b;
    b = COMMON_BITS;
    b[BIT_SURPRISE_DOWN] = !upstream; // R6
    b[BIT_ACCESS_VIOL] = !upstream; // R9
    b[BIT_INTERNAL] = internal; // R10
    return b;
  endfunction

  // expand byte enables to a bit mask
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // merge written bytes into an old value
  function automatic logic [31:0] merge_be(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0] be);
    return (old_val & ~be_bits(be)) | (new_val & be_bits(be));
  endfunction

  localparam logic [31:0] IMPL_BITS = port_bits(IS_UPSTREAM, HAS_INTERNAL_ERR);
  // severity bits software may change; upstream surprise-down is fixed
  localparam logic [31:0] SEV_WR_BITS = IMPL_BITS;
  localparam logic [31:0] CAP_HEADER_VAL =
    ({20'h00000, IS_UPSTREAM ? NEXT_CAP_UPSTREAM : NEXT_CAP_DOWNSTREAM}
      << NEXT_CAP_LSB) |
    ({28'h0000000, CAP_VERSION} << CAP_VER_LSB) |
    ({16'h0000, CAP_ID} << CAP_ID_LSB); // R4 R5

  // address decode
  logic wr_tlp;
  logic wr_dllp;
  logic wr_flags;
  logic wr_masks;
  logic wr_fatal;

  assign wr_tlp = cfg_wr_in && (cfg_addr_in == OFS_BAD_TLP_COUNT);
  assign wr_dllp = cfg_wr_in && (cfg_addr_in == OFS_BAD_DLLP_COUNT);
  assign wr_flags = cfg_wr_in && (cfg_addr_in == OFS_UNCOR_FLAGS);
  assign wr_masks = cfg_wr_in && (cfg_addr_in == OFS_UNCOR_MASKS);
  assign wr_fatal = cfg_wr_in && (cfg_addr_in == OFS_UNCOR_FATALITY);

  // bad packet counters
  logic [CNT_W-1:0] tlp_count;
  logic [CNT_W-1:0] dllp_count;
  logic [CNT_W-1:0] tlp_load;
  logic [CNT_W-1:0] dllp_load;
  logic [31:0] tlp_count_w;
  logic [31:0] dllp_count_w;
  logic [31:0] tlp_merge;
  logic [31:0] dllp_merge;

  always_comb begin
    tlp_count_w = '0;
    dllp_count_w = '0;
    tlp_count_w[CNT_W-1:0] = tlp_count;
    dllp_count_w[CNT_W-1:0] = dllp_count;
  end

  assign tlp_merge = merge_be(tlp_count_w, cfg_wdata_in, cfg_be_in);
  assign dllp_merge = merge_be(dllp_count_w, cfg_wdata_in, cfg_be_in);
  assign tlp_load = tlp_merge[CNT_W-1:0];
  assign dllp_load = dllp_merge[CNT_W-1:0];

  sat_err_counter #(
    .WIDTH(CNT_W)
  ) u_tlp_count (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .inc_in(bad_tlp_in), // R1
    .load_in(wr_tlp),
    .load_val_in(tlp_load),
    .count_out(tlp_count)
  );

  sat_err_counter #(
    .WIDTH(CNT_W)
  ) u_dllp_count (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .inc_in(bad_dllp_in), // R2
    .load_in(wr_dllp),
    .load_val_in(dllp_load),
    .count_out(dllp_count)
  );

  // uncorrectable status
  logic [31:0] flags;
  logic [31:0] evt_live;

  // only positions present on this port can ever be raised
  assign evt_live = uncor_evt_in & IMPL_BITS; // R6 R7 R8 R9 R10 R11

  sticky_err_flags u_flags (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .evt_in(evt_live),
    .impl_in(IMPL_BITS),
    .force_rw_in(force_err_en_in),
    .wr_bits_in(wr_flags ? be_bits(cfg_be_in) : 32'h0000_0000),
    .wr_data_in(cfg_wdata_in),
    .flags_out(flags)
  );

  // mask register; reserved positions keep their reset value
  logic [31:0] masks_r;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      masks_r <= MASKS_RESET; // R14
    end else if (wr_masks) begin
      masks_r <= (masks_r & ~(IMPL_BITS & be_bits(cfg_be_in))) |
                 (cfg_wdata_in & IMPL_BITS & be_bits(cfg_be_in));
    end
  end

  // severity register
  logic [31:0] fatality_r;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      fatality_r <= FATALITY_RESET; // R16
    end else if (wr_fatal) begin
      fatality_r <= (fatality_r & ~(SEV_WR_BITS & be_bits(cfg_be_in))) |
                    (cfg_wdata_in & SEV_WR_BITS & be_bits(cfg_be_in)); // R17
    end
  end

  // error reporting from events seen this cycle
  logic [31:0] report;
  logic [31:0] sev_eff;

  // upstream surprise-down is always read as fatal, whatever was loaded
  always_comb begin
    sev_eff = fatality_r;
    if (IS_UPSTREAM) begin
      sev_eff[BIT_SURPRISE_DOWN] = 1'b1; // R17
    end
  end

  assign report = evt_live & ~masks_r; // R13

  logic fatal_r;
  logic nonfatal_r;
  logic advisory_r;
  logic [31:0] log_req_r;

  // one-cycle pulses, one cycle after the event
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      fatal_r <= 1'b0;
      nonfatal_r <= 1'b0;
      advisory_r <= 1'b0;
      log_req_r <= 32'h0000_0000;
    end else begin
      fatal_r <= |(report & sev_eff); // R15 R18
      nonfatal_r <= |(report & ~sev_eff & ~ADVISORY_BITS); // R18
      advisory_r <= |(report & ~sev_eff & ADVISORY_BITS); // R15
      log_req_r <= report; // R13
    end
  end

  assign fatal_err_out = fatal_r;
  assign nonfatal_err_out = nonfatal_r;
  assign advisory_err_out = advisory_r;
  assign log_req_out = log_req_r;

  // read port: data registered one cycle after the strobe
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic rvalid_r;

  always_comb begin
    unique case (cfg_addr_in)
      OFS_BAD_TLP_COUNT: rdata_nxt = tlp_count_w;
      OFS_BAD_DLLP_COUNT: rdata_nxt = dllp_count_w;
      OFS_CAP_HEADER: rdata_nxt = CAP_HEADER_VAL; // R4 R5
      OFS_UNCOR_FLAGS: rdata_nxt = flags;
      OFS_UNCOR_MASKS: rdata_nxt = masks_r;
      OFS_UNCOR_FATALITY: rdata_nxt = sev_eff;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cfg_rd_in;
      if (cfg_rd_in) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign cfg_rdata_out = rdata_r;
  assign cfg_rvalid_out = rvalid_r;

endmodule

/* src/sat_err_counter.sv */
// saturating event counter with a software load port
// assumes inc_in is a one-cycle pulse per counted packet
module sat_err_counter
  import err_report_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // events and software load
  input wire logic inc_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_val_in,
  // count
  output logic [WIDTH-1:0] count_out
);

  logic [WIDTH-1:0] count_r;

  // a software load wins over a same-cycle increment
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      count_r <= COUNT_RESET[WIDTH-1:0];
    end else if (load_in) begin
      count_r <= load_val_in;
    end else if (inc_in && (count_r != {WIDTH{1'b1}})) begin
      count_r <= count_r + 1'b1; // R3
    end
  end

  assign count_out = count_r;

endmodule

/* src/sticky_err_flags.sv */
// sticky write-one-to-clear error flags with a force mode
// assumes evt_in carries one-cycle pulses, impl_in is constant
module sticky_err_flags
  import err_report_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // events and software access
  input wire logic [31:0] evt_in,
  input wire logic [31:0] impl_in,
  input wire logic force_rw_in,
  input wire logic [31:0] wr_bits_in,
  input wire logic [31:0] wr_data_in,
  // flags
  output logic [31:0] flags_out
);

  logic [31:0] flags_r;
  logic [31:0] flags_nxt;

  always_comb begin
    if (force_rw_in) begin
      flags_nxt = (flags_r & ~wr_bits_in) | (wr_data_in & wr_bits_in); // R12
    end else begin
      flags_nxt = flags_r & ~(wr_bits_in & wr_data_in); // R12
    end
    // a new error wins over a clear in the same cycle
    flags_nxt = (flags_nxt | evt_in) & impl_in; // R11
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      flags_r <= FLAGS_RESET; // R12
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

endmodule
